// ===== deaf_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module deaf_bus_model (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Transfer port
  input  wire logic       bus_req,
  input  wire logic [1:0] bus_chan,
  output logic            bus_ack,
  output logic            bus_err,
  // Answer controls
  input  wire logic [7:0] lat,
  input  wire logic       err_next
);
  logic [7:0] wait_cnt;
  int         units [4];
  // Answer after lat wait cycles, fail the unit when asked
  assign bus_ack = bus_req && (wait_cnt == lat);
  assign bus_err = bus_ack && err_next;
  // Wait counter and per-channel tally of finished units
  always @(posedge core_clk)
  begin
    if (rst || !bus_req || bus_ack)
      wait_cnt <= 8'h00;
    else
      wait_cnt <= wait_cnt + 8'h01;
    if (!rst && bus_ack && !bus_err)
      units[bus_chan] <= units[bus_chan] + 1;
  end
endmodule
`default_nettype wire

// ===== deaf_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "deaf_defs.vh"

module deaf_chan (
  // Clock and control
  input  wire        core_clk,
  input  wire        rst,
  input  wire        ce,
  // Register writes
  input  wire [31:0] wdata,
  input  wire [31:0] wmask,
  input  wire        wr_src,
  input  wire        wr_dst,
  input  wire        wr_cnt,
  input  wire        wr_ctl,
  input  wire        rd_end_seen,
  // Requests and flow
  input  wire        ext_req_n,
  input  wire        periph_req,
  input  wire        global_ok,
  input  wire        unit_done,
  // State out
  output reg  [31:0] source_pointer,
  output reg  [31:0] destination_pointer,
  output reg  [23:0] transfer_counter,
  output wire [31:0] channel_control_reg,
  output wire        enabled,
  output wire        pending,
  output wire        last_unit,
  output wire        burst,
  output wire [1:0]  unit_size,
  output wire [1:0]  addr_mode,
  output wire        transfer_done_irq
);

  reg        channel_enable;
  reg        transfer_end_flag;
  reg        end_seen;
  reg        end_irq_enable;
  reg        unit_size_select_low;
  reg        unit_size_select_high;
  reg [1:0]  req_mode;
  reg [1:0]  amode;
  reg        burst_mode;
  reg        periph_pend;
  reg [31:0] step;
  wire [31:0] ctl_merged;

  // Read image of the control register
  assign channel_control_reg = {22'h00_0000, burst_mode, amode, req_mode,
                                unit_size_select_high, unit_size_select_low,
                                end_irq_enable, transfer_end_flag, channel_enable};
  assign ctl_merged = (channel_control_reg & ~wmask) | (wdata & wmask);

  // Unit size to pointer step
  always @*
  begin
    case ({unit_size_select_high, unit_size_select_low})
      2'b00:   step = 32'h0000_0001;
      2'b01:   step = 32'h0000_0002;
      2'b10:   step = 32'h0000_0004;
      default: step = 32'h0000_0010;
    endcase
  end

  // Pointers, counter and control fields
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      source_pointer        <= `DEAF_RST_PTR;
      destination_pointer   <= `DEAF_RST_PTR;
      transfer_counter      <= `DEAF_RST_CNT;
      channel_enable        <= 1'b0;
      transfer_end_flag     <= 1'b0;
      end_seen              <= 1'b0;
      end_irq_enable        <= 1'b0;
      unit_size_select_low  <= 1'b0;
      unit_size_select_high <= 1'b0;
      req_mode              <= `DEAF_RM_AUTO;
      amode                 <= `DEAF_AM_DUAL_DIR;
      burst_mode            <= 1'b0;
      periph_pend           <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_src)
        source_pointer <= (source_pointer & ~wmask) | (wdata & wmask);
      else if (unit_done)
        source_pointer <= source_pointer + step;
      if (wr_dst)
        destination_pointer <= (destination_pointer & ~wmask) | (wdata & wmask);
      else if (unit_done)
        destination_pointer <= destination_pointer + step;
      // Counter steps down once per finished unit
      if (wr_cnt)
        transfer_counter <= (transfer_counter & ~wmask[23:0]) | (wdata[23:0] & wmask[23:0]);
      else if (unit_done)
        transfer_counter <= transfer_counter - `DEAF_CNT_ONE;
      if (wr_ctl)
      begin
        channel_enable        <= ctl_merged[`DEAF_CC_ENABLE];
        end_irq_enable        <= ctl_merged[`DEAF_CC_IRQ_EN];
        unit_size_select_low  <= ctl_merged[`DEAF_CC_SIZE_LO];
        unit_size_select_high <= ctl_merged[`DEAF_CC_SIZE_HI];
        req_mode              <= ctl_merged[`DEAF_CC_RMODE_HI:`DEAF_CC_RMODE_LO];
        amode                 <= ctl_merged[`DEAF_CC_AMODE_HI:`DEAF_CC_AMODE_LO];
        burst_mode            <= ctl_merged[`DEAF_CC_BURST];
      end
      // End flag: set wins, clear needs a prior read of one
      if (unit_done && last_unit)
      begin
        transfer_end_flag <= 1'b1;
        end_seen          <= 1'b0;
      end
      else if (wr_ctl && !ctl_merged[`DEAF_CC_END_FLAG] && end_seen)
      begin
        transfer_end_flag <= 1'b0;
        end_seen          <= 1'b0;
      end
      else if (rd_end_seen && transfer_end_flag)
        end_seen <= 1'b1;
      // Peripheral request latch, one unit per request
      if (periph_req)
        periph_pend <= 1'b1;
      else if (unit_done)
        periph_pend <= 1'b0;
    end
  end

  // Channel gating and request sources
  assign enabled   = channel_enable & ~transfer_end_flag & global_ok;
  assign pending   = (req_mode == `DEAF_RM_AUTO)   ? 1'b1 :
                     (req_mode == `DEAF_RM_EXT)    ? ~ext_req_n :
                     (req_mode == `DEAF_RM_PERIPH) ? periph_pend : 1'b0;
  assign last_unit = (transfer_counter == `DEAF_CNT_ONE);
  assign burst     = burst_mode;
  assign unit_size = {unit_size_select_high, unit_size_select_low};
  assign addr_mode = amode;
  assign transfer_done_irq = transfer_end_flag & end_irq_enable;

endmodule

`default_nettype wire

// ===== deaf_ctrl.v
// Notes on behaviour
// - A non-maskable interrupt always sets the abort flag, running or suspended.
// - Writing one to the abort flag does nothing; zero clears after reading one.
// - Master enable resets to zero; zero stops all channels, one allows them.
// - Clearing master enable during a transfer suspends all channels.
// - End flag, cleared enable, abort flag or address error disable a channel.
// - Pending channels are served in priority order and stop at their end.
// - Requests come from automatic, external pin or peripheral sources.
// - Single address and dual direct or indirect address modes are supported.
// - Burst keeps the bus between units; cycle steal releases it.
// - Each accepted request moves exactly one unit of the selected size.
// - Automatic mode starts as soon as channel and master enable are set.
// - The transfer counter drops by one after each finished unit.
// - Counter reaching zero ends the channel, raising done interrupt if enabled.
// - An address error or non-maskable interrupt aborts the ongoing transfer.
// - Clearing channel or master enable aborts the transfer.
// - Address error sets its flag, suspends all, clears by zero after reading one.
// - Priority field: 00, 01, 10 fixed orders, 11 round robin.
`timescale 1ns/1ps
`default_nettype none
`include "deaf_defs.vh"

module deaf_ctrl (
  // Clock, reset, enable
  input  wire        core_clk,
  input  wire        rst,
  input  wire        ce,
  // Avalon-MM slave
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  // Events and request sources
  input  wire        nmi_event,
  input  wire [3:0]  ext_req_n,
  input  wire [3:0]  periph_req,
  // System bus transfer port
  output wire        bus_req,
  input  wire        bus_ack,
  input  wire        bus_err,
  output reg  [31:0] bus_src,
  output reg  [31:0] bus_dst,
  output reg  [1:0]  bus_size,
  output reg  [1:0]  bus_addr_mode,
  output reg  [1:0]  bus_chan,
  output wire        bus_hold,
  output reg         transfer_abort,
  // Completion interrupts
  output wire [3:0]  transfer_done_irq
);

  // Transfer engine states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_XFER = 3'b100;

  reg  [2:0]   state;
  reg  [2:0]   next_state;
  reg  [1:0]   cur;
  reg          burst_q;
  reg  [1:0]   rr_first;
  reg          ack_q;
  reg          master_enable;
  reg          abort_interrupt_flag;
  reg          abort_seen;
  reg          address_error_flag;
  reg          ae_seen;
  reg          priority_select_high;
  reg          priority_select_low;
  reg  [7:0]   order;
  reg  [1:0]   pick;
  reg  [31:0]  next_readdata;
  integer      i;

  wire [31:0]  wmask;
  wire         rd_take;
  wire         wr_take;
  wire         op_sel;
  wire         ch_blk;
  wire [1:0]   rk;
  wire [31:0]  op_image;
  wire [31:0]  op_merged;
  wire         global_ok;
  wire [3:0]   ch_en;
  wire [3:0]   ch_pend;
  wire [3:0]   ch_last;
  wire [3:0]   ch_burst;
  wire [3:0]   elig;
  wire [3:0]   unit_done;
  wire [127:0] src_all;
  wire [127:0] dst_all;
  wire [95:0]  cnt_all;
  wire [127:0] ctl_all;
  wire [7:0]   size_all;
  wire [7:0]   amode_all;
  wire         cur_ok;
  wire         cur_pend;
  wire         err_abort;

  // Avalon handshake: one wait cycle, then the access is taken
  assign avs_waitrequest = (avs_read | avs_write) & ~(ack_q & ce);
  assign rd_take = ce & ack_q & avs_read;
  assign wr_take = ce & ack_q & avs_write;
  assign wmask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // Address decode
  assign op_sel = (avs_address == `DEAF_IDX_OPCTL);
  assign ch_blk = (avs_address[4:2] >= `DEAF_IDX_CH_FIRST) &&
                  (avs_address[4:2] <= `DEAF_IDX_CH_LAST);
  assign rk     = avs_address[3:2] - 2'd1;

  // Operation control image and byte-lane merge
  assign op_image  = {22'h00_0000, priority_select_high, priority_select_low, 5'h00,
                      address_error_flag, abort_interrupt_flag, master_enable};
  assign op_merged = (op_image & ~wmask) | (avs_writedata & wmask);

  // Shared gating of all channels
  assign global_ok = master_enable & ~abort_interrupt_flag & ~address_error_flag;

  // Four channels sharing the global flags
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : chan
      localparam integer BLKI = g + 1;
      localparam [2:0] BLK = BLKI[2:0];
      wire sel = (avs_address[4:2] == BLK);
      deaf_chan u_chan (
        .core_clk            (core_clk),
        .rst                 (rst),
        .ce                  (ce),
        .wdata               (avs_writedata),
        .wmask               (wmask),
        .wr_src              (wr_take & sel & (avs_address[1:0] == `DEAF_FLD_SRC)),
        .wr_dst              (wr_take & sel & (avs_address[1:0] == `DEAF_FLD_DST)),
        .wr_cnt              (wr_take & sel & (avs_address[1:0] == `DEAF_FLD_CNT)),
        .wr_ctl              (wr_take & sel & (avs_address[1:0] == `DEAF_FLD_CTL)),
        .rd_end_seen         (rd_take & sel & (avs_address[1:0] == `DEAF_FLD_CTL)
                              & avs_readdata[`DEAF_CC_END_FLAG]),
        .ext_req_n           (ext_req_n[g]),
        .periph_req          (periph_req[g]),
        .global_ok           (global_ok),
        .unit_done           (unit_done[g]),
        .source_pointer      (src_all[32*g+31:32*g]),
        .destination_pointer (dst_all[32*g+31:32*g]),
        .transfer_counter    (cnt_all[24*g+23:24*g]),
        .channel_control_reg (ctl_all[32*g+31:32*g]),
        .enabled             (ch_en[g]),
        .pending             (ch_pend[g]),
        .last_unit           (ch_last[g]),
        .burst               (ch_burst[g]),
        .unit_size           (size_all[2*g+1:2*g]),
        .addr_mode           (amode_all[2*g+1:2*g]),
        .transfer_done_irq   (transfer_done_irq[g])
      );
      // Finished unit on the channel being served
      assign unit_done[g] = (state == ST_XFER) & (cur == g) & cur_ok & bus_ack & ~bus_err;
    end
  endgenerate

  assign elig     = ch_en & ch_pend;
  assign cur_ok   = ch_en[cur];
  assign cur_pend = ch_pend[cur];
  assign err_abort = (state == ST_XFER) & cur_ok & bus_ack & bus_err;

  // Read data mux, unmapped words read as zero
  always @*
  begin
    next_readdata = 32'h0000_0000;
    if (op_sel)
      next_readdata = op_image;
    else if (ch_blk)
    begin
      if (avs_address[1:0] == `DEAF_FLD_SRC)
        next_readdata = src_all[32*rk +: 32];
      else if (avs_address[1:0] == `DEAF_FLD_DST)
        next_readdata = dst_all[32*rk +: 32];
      else if (avs_address[1:0] == `DEAF_FLD_CNT)
        next_readdata = {8'h00, cnt_all[24*rk +: 24]};
      else
        next_readdata = ctl_all[32*rk +: 32];
    end
  end

  // Bus slave timing and read capture
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read && !ack_q)
        avs_readdata <= next_readdata;
    end
  end

  // Operation control register and global flags
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      master_enable        <= 1'b0;
      abort_interrupt_flag <= 1'b0;
      abort_seen           <= 1'b0;
      address_error_flag   <= 1'b0;
      ae_seen              <= 1'b0;
      priority_select_high <= 1'b0;
      priority_select_low  <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_take && op_sel)
      begin
        master_enable        <= op_merged[`DEAF_OP_MASTER_EN];
        priority_select_high <= op_merged[`DEAF_OP_PRI_HI];
        priority_select_low  <= op_merged[`DEAF_OP_PRI_LO];
      end
      // Abort flag: event wins, ones written are ignored
      if (nmi_event)
      begin
        abort_interrupt_flag <= 1'b1;
        abort_seen           <= 1'b0;
      end
      else if (wr_take && op_sel && !op_merged[`DEAF_OP_ABORT_FLAG] && abort_seen)
      begin
        abort_interrupt_flag <= 1'b0;
        abort_seen           <= 1'b0;
      end
      else if (rd_take && op_sel && avs_readdata[`DEAF_OP_ABORT_FLAG])
        abort_seen <= 1'b1;
      // Address error flag, same clearing discipline
      if (err_abort)
      begin
        address_error_flag <= 1'b1;
        ae_seen            <= 1'b0;
      end
      else if (wr_take && op_sel && !op_merged[`DEAF_OP_ADDR_ERR] && ae_seen)
      begin
        address_error_flag <= 1'b0;
        ae_seen            <= 1'b0;
      end
      else if (rd_take && op_sel && avs_readdata[`DEAF_OP_ADDR_ERR])
        ae_seen <= 1'b1;
    end
  end

  // Channel order for the current priority mode
  always @*
  begin
    case ({priority_select_high, priority_select_low})
      `DEAF_PRI_0123: order = `DEAF_ORDER_0123;
      `DEAF_PRI_0231: order = `DEAF_ORDER_0231;
      `DEAF_PRI_2013: order = `DEAF_ORDER_2013;
      default:        order = {rr_first + 2'd3, rr_first + 2'd2, rr_first + 2'd1, rr_first};
    endcase
  end

  // Highest-ranked eligible channel
  always @*
  begin
    pick = order[1:0];
    for (i = 3; i >= 0; i = i - 1)
      if (elig[order[2*i +: 2]])
        pick = order[2*i +: 2];
  end

  // Next state of the transfer engine
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (|elig)
          next_state = ST_LOAD;
      ST_LOAD:
        if (!cur_ok || !cur_pend)
          next_state = ST_IDLE;
        else
          next_state = ST_XFER;
      ST_XFER:
        if (!cur_ok)
          next_state = ST_IDLE;
        else if (bus_ack && bus_err)
          next_state = ST_IDLE;
        else if (bus_ack)
          next_state = (burst_q && !ch_last[cur]) ? ST_LOAD : ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Engine registers and bus-side data
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state          <= ST_IDLE;
      cur            <= 2'd0;
      burst_q        <= 1'b0;
      rr_first       <= 2'd0;
      transfer_abort <= 1'b0;
      bus_src        <= 32'h0000_0000;
      bus_dst        <= 32'h0000_0000;
      bus_size       <= 2'd0;
      bus_addr_mode  <= `DEAF_AM_DUAL_DIR;
      bus_chan       <= 2'd0;
    end
    else if (ce)
    begin
      state          <= next_state;
      transfer_abort <= 1'b0;
      if (state == ST_IDLE && |elig)
      begin
        cur     <= pick;
        burst_q <= ch_burst[pick];
      end
      // Snapshot the unit to move
      if (state == ST_LOAD && cur_ok && cur_pend)
      begin
        bus_src       <= src_all[32*cur +: 32];
        bus_dst       <= dst_all[32*cur +: 32];
        bus_size      <= size_all[2*cur +: 2];
        bus_addr_mode <= amode_all[2*cur +: 2];
        bus_chan      <= cur;
      end
      // Aborts leave one pulse for the bus side
      if ((state != ST_IDLE && !cur_ok) || err_abort)
        transfer_abort <= 1'b1;
      // Served channel drops to last place in round robin
      if (|unit_done)
        rr_first <= cur + 2'd1;
    end
  end

  // Bus request gated by live enable
  assign bus_req  = (state == ST_XFER) & cur_ok;
  // Burst holds the bus between units
  assign bus_hold = burst_q & (state != ST_IDLE);

endmodule

`default_nettype wire

// ===== deaf_defs.vh
`ifndef DEAF_DEFS_VH
`define DEAF_DEFS_VH

// Word indices on the register bus (byte address is four times the index)
`define DEAF_IDX_OPCTL     5'h00
`define DEAF_IDX_CH_FIRST  3'h1
`define DEAF_IDX_CH_LAST   3'h4
`define DEAF_FLD_SRC       2'h0
`define DEAF_FLD_DST       2'h1
`define DEAF_FLD_CNT       2'h2
`define DEAF_FLD_CTL       2'h3

// Operation control register fields
`define DEAF_OP_MASTER_EN  0
`define DEAF_OP_ABORT_FLAG 1
`define DEAF_OP_ADDR_ERR   2
`define DEAF_OP_PRI_LO     8
`define DEAF_OP_PRI_HI     9

// Channel control register fields
`define DEAF_CC_ENABLE     0
`define DEAF_CC_END_FLAG   1
`define DEAF_CC_IRQ_EN     2
`define DEAF_CC_SIZE_LO    3
`define DEAF_CC_SIZE_HI    4
`define DEAF_CC_RMODE_LO   5
`define DEAF_CC_RMODE_HI   6
`define DEAF_CC_AMODE_LO   7
`define DEAF_CC_AMODE_HI   8
`define DEAF_CC_BURST      9

// Request modes
`define DEAF_RM_AUTO       2'h0
`define DEAF_RM_EXT        2'h1
`define DEAF_RM_PERIPH     2'h2

// Address modes
`define DEAF_AM_DUAL_DIR   2'h0
`define DEAF_AM_DUAL_IND   2'h1
`define DEAF_AM_SINGLE     2'h2

// Priority modes
`define DEAF_PRI_0123      2'h0
`define DEAF_PRI_0231      2'h1
`define DEAF_PRI_2013      2'h2
`define DEAF_PRI_RROBIN    2'h3

// Fixed orders, first channel in the low pair
`define DEAF_ORDER_0123    8'b11_10_01_00
`define DEAF_ORDER_0231    8'b01_11_10_00
`define DEAF_ORDER_2013    8'b11_01_00_10

// Reset values and widths
`define DEAF_RST_PTR       32'h0000_0000
`define DEAF_RST_CNT       24'h00_0000
`define DEAF_CNT_W         24
`define DEAF_CNT_ONE       24'h00_0001

`endif

// ===== deaf_props.sv
`timescale 1ns/1ps
`default_nettype none
module deaf_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  // Events and transfer port
  input wire logic        nmi_event,
  input wire logic        bus_req,
  input wire logic        bus_ack,
  input wire logic        bus_err,
  input wire logic [31:0] bus_src,
  input wire logic [1:0]  bus_chan,
  input wire logic        bus_hold,
  input wire logic        transfer_abort,
  input wire logic [3:0]  transfer_done_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Unit finished cleanly, unit failed on address
  sequence s_unit_ok;
    bus_req && bus_ack && !bus_err;
  endsequence
  sequence s_unit_bad;
    bus_req && bus_ack && bus_err;
  endsequence
  a_wait_one_cycle:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access waited more than one cycle");
  a_nmi_stops_req:
    assert property (nmi_event |=> !bus_req [*3])
    else $error("transfer requested while abort flag set");
  a_nmi_abort_pulse:
    assert property (bus_req && !bus_ack && nmi_event |=> !bus_req ##[0:1] transfer_abort)
    else $error("abort event did not abort transfer");
  a_abort_single:
    assert property (transfer_abort |=> !transfer_abort)
    else $error("abort pulse longer than one cycle");
  a_err_stops_req:
    assert property (s_unit_bad |=> !bus_req [*3])
    else $error("transfer requested after address error");
  a_steal_gap:
    assert property (s_unit_ok ##0 !bus_hold |=> !bus_req [*2])
    else $error("cycle steal kept the bus");
  a_ptr_stand:
    assert property (bus_req && !bus_ack |=> $stable(bus_src) && $stable(bus_chan))
    else $error("unit address changed before answer");
  a_irq_cause:
    assert property (|(transfer_done_irq & ~$past(transfer_done_irq))
      |-> $past(bus_req && bus_ack && !bus_err) || $past(avs_write))
    else $error("done interrupt rose without cause");
endmodule
bind deaf_ctrl deaf_props u_deaf_props (.core_clk, .rst, .avs_read, .avs_write,
  .avs_waitrequest, .nmi_event, .bus_req, .bus_ack, .bus_err, .bus_src, .bus_chan,
  .bus_hold, .transfer_abort, .transfer_done_irq);
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // Design inputs
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic        nmi_event = 1'b0;
  logic [3:0]  ext_req_n = 4'hf;
  logic [3:0]  periph_req = 4'h0;
  logic [7:0]  lat = 8'h02;
  logic        err_next = 1'b0;
  // Design outputs
  logic [31:0] avs_readdata, bus_src, bus_dst;
  logic        avs_waitrequest, bus_req, bus_ack, bus_err, bus_hold, transfer_abort;
  logic [1:0]  bus_size, bus_addr_mode, bus_chan;
  logic [3:0]  transfer_done_irq;
  // Bench state
  int          err_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          exp_op [4] = '{3, 5, 0, 1};
  int          n_abort = 0;
  int          abort_base;
  logic        hold_seen = 1'b0;
  logic [31:0] rd;

  always #25 core_clk = ~core_clk;

  deaf_ctrl u_deaf_ctrl (.core_clk, .rst, .ce, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .nmi_event,
    .ext_req_n, .periph_req, .bus_req, .bus_ack, .bus_err, .bus_src, .bus_dst, .bus_size,
    .bus_addr_mode, .bus_chan, .bus_hold, .transfer_abort, .transfer_done_irq);
  deaf_bus_model u_deaf_bus_model (.core_clk, .rst, .bus_req, .bus_chan, .bus_ack,
    .bus_err, .lat, .err_next);

  // Track aborts, burst holding and the run limit
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (transfer_abort === 1'b1)
      n_abort <= n_abort + 1;
    if (bus_hold === 1'b1)
      hold_seen <= 1'b1;
    if (cycles == 20000)
    begin
      err_count++;
      final_report;
    end
  end

  task final_report;
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One register access, held until waitrequest is low
  task bus_op(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task rchk(input logic [4:0] a, input logic [31:0] exp, input string nm);
    bus_op(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask

  // Wait for unit count of a channel, or for a request when ch is 4
  task wait_cond(input int ch, input int n);
    int k;
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (k < 3000 && ((ch < 4) ? u_deaf_bus_model.units[ch] < n : bus_req !== 1'b1));
  endtask

  // Reading control first lets the control write clear the end flag
  task cfg(input int ch, input logic [23:0] cnt, input logic [31:0] ctl);
    logic [4:0] b;
    b = 5'(4 + 4 * ch);
    bus_op(1'b0, b + 5'h03, 32'h0);
    bus_op(1'b1, b, 32'h0000_1000);
    bus_op(1'b1, b + 5'h01, 32'h0000_2000);
    bus_op(1'b1, b + 5'h02, {8'h00, cnt});
    bus_op(1'b1, b + 5'h03, ctl);
  endtask

  task pulse_nmi;
    @(posedge core_clk);
    nmi_event <= 1'b1;
    @(posedge core_clk);
    nmi_event <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rchk(5'h00, 32'h0, "opctl reset");
    rchk(5'h07, 32'h0, "ctl0 reset");
    bus_op(1'b1, 5'h01, 32'hffff_ffff);
    rchk(5'h01, 32'h0, "unmapped word");
    pulse_nmi;
    bus_op(1'b1, 5'h00, 32'h0);
    rchk(5'h00, 32'h2, "flag blind clear");
    pulse_nmi;
    bus_op(1'b1, 5'h00, 32'h0);
    rchk(5'h00, 32'h2, "flag set after read");
    bus_op(1'b1, 5'h00, 32'h2);
    rchk(5'h00, 32'h2, "flag write one");
    bus_op(1'b1, 5'h00, 32'h0);
    rchk(5'h00, 32'h0, "flag cleared");
    // Automatic transfer waits for master enable, then runs three units
    cfg(0, 24'h00_0003, 32'h0000_0015);
    repeat (20) @(posedge core_clk);
    check("units before master", 32'(u_deaf_bus_model.units[0]), 32'h0);
    bus_op(1'b1, 5'h00, 32'h1);
    wait_cond(0, 3);
    repeat (10) @(posedge core_clk);
    check("units ch0", 32'(u_deaf_bus_model.units[0]), 32'h3);
    check("done irq", {28'h0, transfer_done_irq}, 32'h1);
    rchk(5'h06, 32'h0, "count ch0");
    rchk(5'h07, 32'h17, "ctl end ch0");
    rchk(5'h04, 32'h0000_100c, "src ch0");
    // Abort by event, address error, master clear and channel clear
    lat <= 8'h14;
    for (int k = 0; k < 4; k++)
    begin
      cfg(1, 24'h00_0002, 32'h0000_0001);
      wait_cond(4, 0);
      abort_base = n_abort;
      case (k)
        0: pulse_nmi;
        1: err_next <= 1'b1;
        2: bus_op(1'b1, 5'h00, 32'h0);
        default: bus_op(1'b1, 5'h0b, 32'h0);
      endcase
      repeat (30) @(posedge core_clk);
      err_next <= 1'b0;
      check("abort pulse", 32'(n_abort - abort_base), 32'h1);
      rchk(5'h0a, 32'h2, "count held");
      rchk(5'h00, 32'(exp_op[k]), "opctl after abort");
      bus_op(1'b1, 5'h00, 32'h1);
      if (k < 3)
        wait_cond(1, 2 * k + 2);
    end
    check("units ch1", 32'(u_deaf_bus_model.units[1]), 32'h6);
    // External level and peripheral pulse requests
    lat <= 8'h00;
    cfg(2, 24'h00_0002, 32'h0000_0021);
    repeat (20) @(posedge core_clk);
    check("no ext request", 32'(u_deaf_bus_model.units[2]), 32'h0);
    ce <= 1'b0;
    ext_req_n <= 4'hb;
    repeat (10) @(posedge core_clk);
    check("frozen engine", 32'(u_deaf_bus_model.units[2]), 32'h0);
    ce <= 1'b1;
    wait_cond(2, 2);
    @(posedge core_clk);
    ext_req_n <= 4'hf;
    rchk(5'h0e, 32'h0, "ext count");
    cfg(2, 24'h00_0002, 32'h0000_0041);
    @(posedge core_clk);
    periph_req <= 4'h4;
    @(posedge core_clk);
    periph_req <= 4'h0;
    repeat (20) @(posedge core_clk);
    check("unit per pulse", 32'(u_deaf_bus_model.units[2]), 32'h3);
    rchk(5'h0e, 32'h1, "periph count");
    // Priority orders, round robin last, with burst, unit sizes and address modes
    for (int k = 0; k < 4; k++)
    begin
      bus_op(1'b1, 5'h00, 32'h0);
      cfg(1, 24'h00_0001, 32'(k << 3 | k << 7 | 32'h0201));
      cfg(2, 24'h00_0001, 32'(k << 3 | k << 7 | 32'h0201));
      bus_op(1'b1, 5'h00, 32'(k << 8 | 1));
      wait_cond(4, 0);
      check("first channel", {30'h0, bus_chan}, (k == 0) ? 32'h1 : 32'h2);
      check("unit size", {30'h0, bus_size}, 32'(k));
      check("address mode", {30'h0, bus_addr_mode}, 32'(k));
      repeat (20) @(posedge core_clk);
    end
    check("burst hold", {31'h0, hold_seen}, 32'h1);
    final_report;
  end
endmodule
`default_nettype wire
